/* File: logic/arx_receiver.sv */
// Summary of operation
// - master mode: 32 bit clocks per sample
// - master bit makes clock and sync outputs
// - master clock 128x, bit clock 32x, sync
// - master bit clock is master clock over four
// - sync from divider or incoming stream
// - unlocked steer oscillator; no data: minimum
// - port reaches status, enable, control, buffer
// - status and enable pairs share addresses 0,1
// - write strobe stores host data at address
// - read strobe drives addressed contents out
// - three buffer modes from two-bit field
// - audio out serially, control into buffer
// - option repeats previous sample on error
// - select zero shows status, one enables
// - system control at 2, serial at 3
// - control and enable registers reset to zero
`timescale 1ns/1ps
`default_nettype none
module arx_receiver (
	input wire logic mclk,
	input wire logic reset,
	output logic recovered_master_clock,
	input wire logic rx_data_present,
	input wire logic rx_lock,
	input wire logic rx_freq_low,
	input wire logic rx_freq_high,
	output logic vco_steer_up,
	output logic vco_steer_down,
	output logic vco_hold_min,
	input wire logic rx_sample_valid,
	input wire logic rx_sample_chan,
	input wire logic [arx_pkg::SAMPLE_W-1:0] rx_sample,
	input wire logic rx_sample_err,
	input wire logic [arx_pkg::ERR_W-1:0] rx_err,
	input wire logic rx_stream_sync,
	input wire logic rx_ctrl_valid,
	input wire logic [1:0] rx_ctrl_kind,
	input wire logic [arx_pkg::ADDR_W-1:0] rx_ctrl_index,
	input wire logic [arx_pkg::DATA_W-1:0] rx_ctrl_byte,
	input wire logic bit_clock_in,
	output logic bit_clock_out,
	output logic bit_clock_oe,
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	output logic frame_sync_oe,
	output logic serial_data_out,
	input wire logic cs_n,
	input wire logic rd_wr,
	input wire logic [arx_pkg::ADDR_W-1:0] addr,
	input wire logic [arx_pkg::DATA_W-1:0] data_in,
	output logic [arx_pkg::DATA_W-1:0] data_out,
	output logic data_oe
);
	import arx_pkg::*;
	localparam int DIV_W = $clog2(MCLK_PER_BCLK);
	localparam int BIT_W = $clog2(BCLK_PER_SAMPLE);
	localparam int GAP_W = $clog2(MCLK_PER_SAMPLE) + 1;
	localparam int PAD_W = BCLK_PER_SAMPLE - SAMPLE_W;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_PER_BCLK - 1);
	localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(MCLK_PER_BCLK / 2 - 1);
	localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(BCLK_PER_SAMPLE - 1);
	localparam logic [BIT_W-1:0] BIT_MID = BIT_W'(BCLK_PER_SAMPLE / 2 - 1);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(MCLK_PER_SAMPLE - 1);
	localparam logic [ADDR_W-1:0] BUF_SIZE = ADDR_W'(BUF_BYTES);

	logic [DATA_W-1:0] sys_ctl_ff, ser_ctl_ff, ier1_ff, ier2_ff;
	logic [DATA_W-1:0] sr1_ff, sr2_ff, data_out_ff, wr_data_ff;
	logic [DATA_W-1:0] buf_mem [BUF_BYTES];
	logic [ADDR_W-1:0] addr_ff;
	logic cs_n_ff, bclk_in_ff, sync_seen_ff, sck_ff, sync_ff;
	logic [DIV_W-1:0] div_ff;
	logic [BIT_W-1:0] bit_ff;
	logic [BCLK_PER_SAMPLE-1:0] shift_ff;
	logic [SAMPLE_W-1:0] sample_ff [2];
	logic [1:0] fresh_ff;
	arx_pp_state_t pp_ff, nxt_pp;
	arx_vco_t vco_ff, nxt_vco;
	logic ctrl_accept;

	// master clock is the recovered oscillator itself
	assign recovered_master_clock = mclk;

	// control decode
	wire master = ser_ctl_ff[SER_MASTER_BIT];
	wire edge_fall = ser_ctl_ff[SER_EDGE_BIT];
	wire sel_ier = sys_ctl_ff[SYS_SELECT_BIT];
	wire repeat_en = sys_ctl_ff[SYS_REPEAT_BIT];
	wire src_stream = sys_ctl_ff[SYS_SRC_BIT];
	wire sync_double = sys_ctl_ff[SYS_DOUBLE_BIT];
	wire [1:0] buf_mode = sys_ctl_ff[SYS_MODE_LSB +: 2];

	// serial clock events
	wire [DIV_W-1:0] nxt_div = div_ff + DIV_W'(1);
	wire m_rise = div_ff == DIV_HALF;
	wire m_fall = div_ff == DIV_LAST;
	wire s_rise = bit_clock_in & ~bclk_in_ff;
	wire s_fall = ~bit_clock_in & bclk_in_ff;
	wire clk_rise = master ? m_rise : s_rise;
	wire clk_fall = master ? m_fall : s_fall;
	wire launch = edge_fall ? clk_fall : clk_rise;
	wire sync_toggle = master & launch &
		(bit_ff == BIT_LAST | (sync_double & bit_ff == BIT_MID));
	wire div_sync = sync_toggle ? ~sync_ff : sync_ff;
	wire nxt_sync = src_stream ? rx_stream_sync : div_sync;
	// slave framing trusts the far clock to give whole 32-bit words
	wire s_load = ~master & launch & (frame_sync_in != sync_seen_ff);
	wire m_load = master & launch & (bit_ff == BIT_LAST);
	wire load = m_load | s_load;
	wire load_chan = master ? nxt_sync : frame_sync_in;
	wire slip_evt = load & ~fresh_ff[load_chan];
	wire keep_old = rx_sample_err & repeat_en;

	// parallel port strobe decode
	wire cs_fall = ~cs_n & cs_n_ff;
	wire cs_rise = cs_n & ~cs_n_ff;
	wire commit_wr = (pp_ff == PP_WRITE) & cs_rise;
	wire commit_rd = (pp_ff == PP_READ) & cs_rise;
	wire wr_buf = commit_wr & (addr_ff >= ADDR_BUF_BASE);
	wire [ADDR_W-1:0] buf_idx = addr - ADDR_BUF_BASE;
	wire [ADDR_W-1:0] wr_idx = addr_ff - ADDR_BUF_BASE;
	wire clr1 = commit_rd & ~sel_ier & (addr_ff == ADDR_STAT1);
	wire clr2 = commit_rd & ~sel_ier & (addr_ff == ADDR_STAT2);
	wire erf_evt = |(rx_err & ier2_ff[ERR_W-1:0]);
	wire [DATA_W-1:0] set1 = (DATA_W'(erf_evt) << SR1_ERF_BIT) |
		(DATA_W'(slip_evt & ~master) << SR1_SLIP_BIT);
	wire [DATA_W-1:0] set2 = DATA_W'(rx_err);
	// read mux
	wire [DATA_W-1:0] stat1_view = sel_ier ? ier1_ff : sr1_ff;
	wire [DATA_W-1:0] stat2_view = sel_ier ? ier2_ff : sr2_ff;
	wire [DATA_W-1:0] rd_val =
		(addr == ADDR_STAT1) ? stat1_view :
		(addr == ADDR_STAT2) ? stat2_view :
		(addr == ADDR_SYS_CTL) ? sys_ctl_ff :
		(addr == ADDR_SER_CTL) ? ser_ctl_ff : buf_mem[buf_idx];

	assign data_oe = ~cs_n & rd_wr;
	assign data_out = data_out_ff;
	assign bit_clock_out = sck_ff;
	assign bit_clock_oe = master;
	assign frame_sync_out = sync_ff;
	assign frame_sync_oe = master;
	assign serial_data_out = shift_ff[BCLK_PER_SAMPLE-1];
	assign vco_steer_up = vco_ff == VCO_UP;
	assign vco_steer_down = vco_ff == VCO_DOWN;
	assign vco_hold_min = vco_ff == VCO_MIN;

	// reserved mode stores nothing rather than guess a layout
	always_comb begin
		case (buf_mode)
		BUF_MODE0: ctrl_accept = rx_ctrl_kind == 2'h0;
		BUF_MODE1: ctrl_accept = rx_ctrl_kind <= 2'h1;
		BUF_MODE2: ctrl_accept = rx_ctrl_kind != 2'h1 && rx_ctrl_kind != 2'h3;
		default: ctrl_accept = 1'b0;
		endcase
	end

	always_comb begin
		nxt_pp = pp_ff;
		case (pp_ff)
		PP_IDLE: if (cs_fall) nxt_pp = rd_wr ? PP_READ : PP_WRITE;
		PP_READ: if (cs_rise) nxt_pp = PP_IDLE;
		PP_WRITE: if (cs_rise) nxt_pp = PP_IDLE;
		default: nxt_pp = PP_IDLE;
		endcase
	end

	always_comb begin
		case ({rx_data_present, rx_lock})
		2'b10: nxt_vco = rx_freq_low ? VCO_UP :
			(rx_freq_high ? VCO_DOWN : VCO_RUN);
		2'b11: nxt_vco = VCO_RUN;
		default: nxt_vco = VCO_MIN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pp_ff <= PP_IDLE;
			vco_ff <= VCO_MIN;
			cs_n_ff <= 1'b1;
			addr_ff <= '0;
			wr_data_ff <= REG_RESET;
			data_out_ff <= REG_RESET;
		end else begin
			pp_ff <= nxt_pp;
			vco_ff <= nxt_vco;
			cs_n_ff <= cs_n;
			if (cs_fall)
				addr_ff <= addr;
			// data is only guaranteed up to the rising strobe edge
			if (pp_ff == PP_WRITE && !cs_n)
				wr_data_ff <= data_in;
			if (data_oe)
				data_out_ff <= rd_val;
		end
	end

	// host registers; hardware set wins over read clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			sys_ctl_ff <= REG_RESET;
			ser_ctl_ff <= REG_RESET;
			ier1_ff <= REG_RESET;
			ier2_ff <= REG_RESET;
			sr1_ff <= REG_RESET;
			sr2_ff <= REG_RESET;
		end else begin
			sr1_ff <= (clr1 ? REG_RESET : sr1_ff) | set1;
			sr2_ff <= (clr2 ? REG_RESET : sr2_ff) | set2;
			if (commit_wr) begin
				if (addr_ff == ADDR_STAT1 && sel_ier)
					ier1_ff <= wr_data_ff;
				if (addr_ff == ADDR_STAT2 && sel_ier)
					ier2_ff <= wr_data_ff;
				if (addr_ff == ADDR_SYS_CTL)
					sys_ctl_ff <= wr_data_ff;
				if (addr_ff == ADDR_SER_CTL)
					ser_ctl_ff <= wr_data_ff;
			end
		end
	end

	// host write wins a same-cycle collision with the stream
	always_ff @(posedge mclk) begin
		if (rx_ctrl_valid && ctrl_accept && rx_ctrl_index < BUF_SIZE)
			buf_mem[rx_ctrl_index] <= rx_ctrl_byte;
		if (wr_buf)
			buf_mem[wr_idx] <= wr_data_ff;
	end

	// serial port timing
	always_ff @(posedge mclk) begin
		if (reset) begin
			div_ff <= '0;
			sck_ff <= 1'b0;
			bit_ff <= '0;
			sync_ff <= 1'b0;
			bclk_in_ff <= 1'b0;
			sync_seen_ff <= 1'b0;
			shift_ff <= '0;
		end else begin
			div_ff <= nxt_div;
			sck_ff <= nxt_div > DIV_HALF;
			bclk_in_ff <= bit_clock_in;
			sync_ff <= nxt_sync;
			if (m_load)
				bit_ff <= '0;
			else if (master && launch)
				bit_ff <= bit_ff + BIT_W'(1);
			if (!master && launch)
				sync_seen_ff <= frame_sync_in;
			if (load)
				shift_ff <= {sample_ff[load_chan], PAD_W'(0)};
			else if (launch)
				shift_ff <= shift_ff << 1;
		end
	end

	// per-channel sample hold; the consumer clears fresh, arrival sets it
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			wire hit = rx_sample_valid & (rx_sample_chan == ch);
			always_ff @(posedge mclk) begin
				if (reset) begin
					sample_ff[ch] <= '0;
					fresh_ff[ch] <= 1'b0;
				end else begin
					if (hit && !keep_old)
						sample_ff[ch] <= rx_sample;
					if (hit)
						fresh_ff[ch] <= 1'b1;
					else if (load && load_chan == ch)
						fresh_ff[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// checks
	logic [GAP_W-1:0] gap_ff;
	logic prime_ff;
	// a serial control write may cut the word in flight short
	wire ser_wr = commit_wr & (addr_ff == ADDR_SER_CTL);
	always_ff @(posedge mclk) begin
		if (reset || !master || ser_wr) begin
			gap_ff <= '0;
			prime_ff <= 1'b0;
		end else if (m_load) begin
			gap_ff <= '0;
			prime_ff <= 1'b1;
		end else begin
			gap_ff <= gap_ff + GAP_W'(1);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	word_period_a: assert property (m_load && prime_ff |-> gap_ff == GAP_LAST)
		else $error("master word not 32 bit clocks long");
	pin_dir_a: assert property (bit_clock_oe == master && frame_sync_oe == master)
		else $error("clock pin direction does not follow master bit");
	bclk_div_a: assert property (master && $rose(bit_clock_out) ##1 master |->
		bit_clock_out ##1 !bit_clock_out ##1 !bit_clock_out ##1 bit_clock_out)
		else $error("bit clock not master clock over four");
	launch_edge_a: assert property (master && edge_fall && !$stable(shift_ff) &&
		$stable(ser_ctl_ff) |-> $fell(bit_clock_out))
		else $error("serial data changed off the falling edge");
	vco_min_a: assert property (!rx_data_present |=> vco_hold_min)
		else $error("oscillator not held at minimum without data");
	bus_release_a: assert property (cs_n || !rd_wr |-> !data_oe)
		else $error("data bus driven outside a read strobe");
	ser_write_a: assert property (commit_wr && addr_ff == ADDR_SER_CTL |=>
		ser_ctl_ff == $past(wr_data_ff))
		else $error("serial control write not stored");
	view_sel_a: assert property (data_oe && addr == ADDR_STAT1 && !sel_ier |=>
		data_out == $past(sr1_ff))
		else $error("status not visible at address 0");
	repeat_hold_a: assert property (rx_sample_valid && keep_old &&
		!rx_sample_chan |=> sample_ff[0] == $past(sample_ff[0]))
		else $error("errored sample replaced held sample");
	reset_zero_a: assert property ($past(reset) |-> sys_ctl_ff == REG_RESET &&
		ier1_ff == REG_RESET && ier2_ff == REG_RESET)
		else $error("control not zero after reset");
endmodule : arx_receiver
`default_nettype wire

/* File: logic/arx_pkg.sv */
package arx_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_STAT1 = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_STAT2 = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_SYS_CTL = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_SER_CTL = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_BUF_BASE = 5'h04;
	localparam int BUF_BYTES = 28;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam int SER_EDGE_BIT = 0;
	localparam int SER_MASTER_BIT = 1;
	localparam int SYS_SELECT_BIT = 0;
	localparam int SYS_MODE_LSB = 1;
	localparam int SYS_REPEAT_BIT = 3;
	localparam int SYS_SRC_BIT = 4;
	localparam int SYS_DOUBLE_BIT = 5;
	localparam int ERR_W = 5;
	localparam int SR1_ERF_BIT = 3;
	localparam int SR1_SLIP_BIT = 4;
	localparam int MCLK_PER_BCLK = 4;
	localparam int BCLK_PER_SAMPLE = 32;
	localparam int SAMPLE_W = 24;
	localparam int MCLK_PER_SAMPLE = MCLK_PER_BCLK * BCLK_PER_SAMPLE;
	typedef enum logic [1:0] {
		BUF_MODE0 = 2'h0,
		BUF_MODE1 = 2'h1,
		BUF_MODE2 = 2'h2,
		BUF_MODE_RSV = 2'h3
	} arx_buf_mode_t;
	typedef enum logic [1:0] {
		PP_IDLE = 2'h0,
		PP_READ = 2'h1,
		PP_WRITE = 2'h3
	} arx_pp_state_t;
	typedef enum logic [1:0] {
		VCO_RUN = 2'h0,
		VCO_UP = 2'h1,
		VCO_DOWN = 2'h3,
		VCO_MIN = 2'h2
	} arx_vco_t;
endpackage : arx_pkg

/* File: test/arx_dsp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stands in for the audio processor that owns the serial clocks in slave mode
module arx_dsp_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic run,
	output logic bit_clock,
	output logic frame_sync
);
	logic [6:0] cnt_ff;
	logic fs_ff;
	always_ff @(posedge mclk) begin
		if (reset || !run) begin
			cnt_ff <= 7'h00;
		end else begin
			cnt_ff <= cnt_ff + 7'h01;
		end
	end
	// 32 clocks of 4 mclk each per sample; still low when stopped
	assign bit_clock = run & cnt_ff[1];
	// sync moves on a falling clock edge, ahead of the next rise
	always_ff @(posedge mclk) begin
		if (reset) begin
			fs_ff <= 1'h0;
		end else if (run && cnt_ff == 7'h7F) begin
			fs_ff <= ~fs_ff;
		end
	end
	assign frame_sync = fs_ff;
endmodule : arx_dsp_model
`default_nettype wire

/* File: test/audio_receiver_port_clocking_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module audio_receiver_port_clocking_tb_top;
	import arx_pkg::*;
	logic mclk = 0, reset = 1, rx_data_present = 0, rx_lock = 0;
	logic rx_freq_low = 0, rx_freq_high = 0, rx_sample_valid = 0;
	logic rx_sample_chan = 0, rx_sample_err = 0, cs_n = 1, rd_wr = 1;
	logic run = 0, es = 1, mst = 0;
	logic [SAMPLE_W-1:0] rx_sample = '0;
	logic [ERR_W-1:0] rx_err = '0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] data_in = '0;
	logic rx_stream_sync = 0, rx_ctrl_valid = 0;
	logic [1:0] rx_ctrl_kind = '0;
	logic [ADDR_W-1:0] rx_ctrl_index = '0;
	logic [DATA_W-1:0] rx_ctrl_byte = '0;
	wire logic recovered_master_clock, vco_steer_up, vco_steer_down;
	wire logic vco_hold_min, bit_clock_in, bit_clock_out, bit_clock_oe;
	wire logic frame_sync_in, frame_sync_out, frame_sync_oe, data_oe;
	wire logic serial_data_out;
	wire logic [DATA_W-1:0] data_out;
	wire logic cap_clk = mst ? bit_clock_out : bit_clock_in;
	wire logic cap_fs = mst ? frame_sync_out : frame_sync_in;
	int failures = 0, num_checks = 0, cyc = 0;
	arx_receiver uut (.mclk, .reset, .recovered_master_clock,
		.rx_data_present, .rx_lock, .rx_freq_low, .rx_freq_high,
		.vco_steer_up, .vco_steer_down, .vco_hold_min, .rx_sample_valid,
		.rx_sample_chan, .rx_sample, .rx_sample_err, .rx_err,
		.rx_stream_sync, .rx_ctrl_valid, .rx_ctrl_kind, .rx_ctrl_index,
		.rx_ctrl_byte, .bit_clock_in,
		.bit_clock_out, .bit_clock_oe, .frame_sync_in, .frame_sync_out,
		.frame_sync_oe, .serial_data_out, .cs_n, .rd_wr, .addr, .data_in,
		.data_out, .data_oe);
	arx_dsp_model dsp (.mclk, .reset, .run, .bit_clock(bit_clock_in),
		.frame_sync(frame_sync_in));
	always #12.5 mclk = ~mclk;
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	// a hung handshake must still end in the report
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_wr <= 1'h0;
		data_in <= d;
		cs_n <= 1'h0;
		repeat (2) @(posedge mclk);
		chk("oe in write", 0, data_oe);
		cs_n <= 1'h1;
		repeat (2) @(posedge mclk);
		data_in <= ~d;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd_wr <= 1'h1;
		cs_n <= 1'h0;
		repeat (2) @(posedge mclk);
		chk("read oe", 1, data_oe);
		chk($sformatf("read %h", a), e, data_out);
		cs_n <= 1'h1;
		@(posedge mclk);
		#1 chk("oe idle", 0, data_oe);
	endtask : rd
	task automatic vco(input logic [3:0] i, input logic [2:0] e);
		@(posedge mclk);
		{rx_data_present, rx_lock, rx_freq_low, rx_freq_high} <= i;
		repeat (2) @(posedge mclk);
		#1 chk("vco", e, {vco_steer_up, vco_steer_down, vco_hold_min});
		chk("master clock", 1, recovered_master_clock);
	endtask : vco
	task automatic send(input logic [23:0] v, input logic er);
		for (int c = 0; c < 2; c++) begin
			@(posedge mclk);
			rx_sample_valid <= 1'h1;
			rx_sample_chan <= c[0];
			rx_sample <= v;
			rx_sample_err <= er;
		end
		@(posedge mclk);
		rx_sample_valid <= 1'h0;
	endtask : send
	// one control byte from the stream side, valid for a single cycle
	task automatic ctl(input logic [1:0] k, input logic [4:0] i,
		input logic [7:0] b);
		@(posedge mclk);
		rx_ctrl_valid <= 1'h1;
		rx_ctrl_kind <= k;
		rx_ctrl_index <= i;
		rx_ctrl_byte <= b;
		@(posedge mclk);
		rx_ctrl_valid <= 1'h0;
	endtask : ctl
	// master clocks between two successive sync changes
	task automatic fs_gap(input int e);
		logic p;
		int n, t;
		n = -1;
		t = 0;
		@(posedge mclk);
		#1 p = frame_sync_out;
		for (int k = 0; k < 600 && t < 2; k++) begin
			@(posedge mclk);
			#1 if (n >= 0) n++;
			if (frame_sync_out !== p) begin
				t++;
				if (t == 1) n = 0;
			end
			p = frame_sync_out;
		end
		if (t < 2) n = -1;
		chk("sync period", e, n);
	endtask : fs_gap
	// one whole word between two sync changes, seen on the sampling edge
	task automatic cap(input logic [31:0] e);
		logic pc, pf, c;
		int n, m;
		logic [31:0] w;
		n = -1;
		m = 0;
		w = '0;
		pc = cap_clk;
		pf = cap_fs;
		for (int k = 0; k < 1000 && n < 33; k++) begin
			@(posedge mclk);
			#1 c = cap_clk;
			if (n >= 0) m++;
			if (es ? (c && !pc) : (!c && pc)) begin
				if (cap_fs !== pf && n >= 0) begin
					chk("word", e, w);
					chk("bits", 32, n);
					chk("mclk per word", 128, m);
					n = 99;
				end else begin
					if (cap_fs !== pf) n = 0;
					if (n >= 0) w = {w[30:0], serial_data_out};
					if (n >= 0) n++;
				end
				pf = cap_fs;
			end
			pc = c;
		end
		if (n != 99) chk("frame seen", 1, 0);
	endtask : cap
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 1'h0;
		for (int a = 0; a < 4; a++) rd(a[4:0], 8'h00);
		vco(4'h0, 3'h1);
		vco(4'hA, 3'h4);
		vco(4'h9, 3'h2);
		vco(4'hC, 3'h0);
		wr(5'h02, 8'h01);
		wr(5'h00, 8'h5A);
		wr(5'h01, 8'h1F);
		rd(5'h00, 8'h5A);
		rd(5'h01, 8'h1F);
		rd(5'h02, 8'h01);
		wr(5'h02, 8'h00);
		wr(5'h00, 8'hA5);
		rd(5'h00, 8'h00);
		@(posedge mclk);
		rx_err <= 5'h04;
		@(posedge mclk);
		rx_err <= 5'h00;
		rd(5'h01, 8'h04);
		rd(5'h00, 8'h08);
		rd(5'h01, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(5'h02, 8'(m * 2));
			rd(5'h02, 8'(m * 2));
		end
		// mode 3 keeps the stream out of the buffer while we test it
		for (int i = 0; i < BUF_BYTES; i++) wr(5'(4 + i), 8'(i * 9 + 3));
		for (int i = 0; i < BUF_BYTES; i++) rd(5'(4 + i), 8'(i * 9 + 3));
		// each mode stores its own kinds of control byte and no other
		wr(5'h02, 8'h00);
		ctl(2'h0, 5'h00, 8'hE1);
		ctl(2'h1, 5'h01, 8'hE2);
		rd(5'h04, 8'hE1);
		rd(5'h05, 8'h0C);
		wr(5'h02, 8'h02);
		ctl(2'h1, 5'h01, 8'hE2);
		ctl(2'h2, 5'h02, 8'hE3);
		rd(5'h05, 8'hE2);
		rd(5'h06, 8'h15);
		wr(5'h02, 8'h04);
		ctl(2'h2, 5'h02, 8'hE3);
		ctl(2'h1, 5'h03, 8'hE4);
		rd(5'h06, 8'hE3);
		rd(5'h07, 8'h1E);
		wr(5'h02, 8'h06);
		ctl(2'h0, 5'h03, 8'hE4);
		rd(5'h07, 8'h1E);
		wr(5'h02, 8'h00);
		mst = 1'h1;
		for (int e = 1; e >= 0; e--) begin
			es = e[0];
			wr(5'h03, {7'h01, es});
			rd(5'h03, {7'h01, es});
			chk("master oe", 3, {bit_clock_oe, frame_sync_oe});
			send(24'hC3A501, 1'h0);
			cap({24'hC3A501, 8'h00});
		end
		es = 1'h1;
		wr(5'h03, 8'h03);
		wr(5'h02, 8'h08);
		send(24'h5E0F71, 1'h1);
		cap({24'hC3A501, 8'h00});
		wr(5'h02, 8'h00);
		send(24'h5E0F71, 1'h1);
		cap({24'h5E0F71, 8'h00});
		wr(5'h02, 8'h20);
		fs_gap(MCLK_PER_SAMPLE / 2);
		wr(5'h02, 8'h10);
		rx_stream_sync <= 1'h1;
		repeat (2) @(posedge mclk);
		#1 chk("stream sync", 1, frame_sync_out);
		@(posedge mclk);
		rx_stream_sync <= 1'h0;
		repeat (2) @(posedge mclk);
		#1 chk("stream sync", 0, frame_sync_out);
		wr(5'h02, 8'h00);
		wr(5'h03, 8'h01);
		mst = 1'h0;
		run <= 1'h1;
		chk("slave oe", 0, {bit_clock_oe, frame_sync_oe});
		send(24'h81F00F, 1'h0);
		cap({24'h81F00F, 8'h00});
		cap({24'h81F00F, 8'h00});
		// one pair only was sent, so the third word found no fresh sample
		rd(5'h00, 8'h10);
		give_verdict();
	end
endmodule : audio_receiver_port_clocking_tb_top
`default_nettype wire
